// File: sts_host_model.sv
/*
  Host model: drives the clock input pin and the serial status link.
  Assumes it runs on the bench system clock and that the bench calls its tasks.
*/
`timescale 1ns/1ns

module sts_host_model (
  input  wire logic mclk_i,    // bench system clock
  input  wire logic sdo_i,     // serial data from the device
  output logic      ext_clk_o, // clock input pin
  output logic      cs_n_o,    // serial select, active low
  output logic      sck_o,     // serial clock
  output logic      sdi_o      // serial data to the device
);
  logic       run_reg  = 1'b0;
  logic [1:0] div_reg  = 2'h0;
  logic       clk_reg  = 1'b0;
  logic       cs_n_reg = 1'b1;
  logic       sck_reg  = 1'b0;
  logic       sdi_reg  = 1'b0;

  assign ext_clk_o = clk_reg;
  assign cs_n_o    = cs_n_reg;
  assign sck_o     = sck_reg;
  assign sdi_o     = sdi_reg;

  // a stop request lets the high half finish, then the pin rests low, never floating
  always @(posedge mclk_i) begin
    if (run_reg || clk_reg) begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h2) begin
        div_reg <= 2'h0;
        clk_reg <= ~clk_reg;
      end
    end
  end

  task automatic clk_run(input logic on);
    @(posedge mclk_i);
    run_reg <= on;
  endtask

  // one 20-bit frame, msb first; sdo is taken before each rising sck
  task automatic xfer(input logic [19:0] din, output logic [19:0] dout);
    @(posedge mclk_i);
    cs_n_reg <= 1'b0;
    repeat (4) @(posedge mclk_i);
    for (int i = 19; i >= 0; i--) begin
      dout[i] = sdo_i;
      sdi_reg <= din[i];
      sck_reg <= 1'b1;
      repeat (2) @(posedge mclk_i);
      sck_reg <= 1'b0;
      repeat (2) @(posedge mclk_i);
    end
    cs_n_reg <= 1'b1;
    sdi_reg  <= ~sdi_reg;
  endtask
endmodule

// File: sts_pkg.sv
/*
  Types of the supply, temperature and clock supervisor.
  Assumes nothing of its surroundings.
*/
package sts_pkg;

  typedef enum logic [1:0] {
    ST_POR,
    ST_UVLO,
    ST_RUN
  } sts_state_t;

endpackage

// File: sts_supervisor.sv
/*
  Supervisor of a stepper driver: temperature warning and shutdown, undervoltage
  and power-up reset, standstill detection, clock source selection, serial status
  shift register and an APB register file.
  Assumes synchronous monitor inputs on mclk_i, a short-to-ground fault input that
  may act without a clock, and an APB master as described in the hand-over.

*/
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "sts_supervisor_params.svh"

module sts_supervisor
  import sts_pkg::*;
#(
  parameter int unsigned STILL_CYCLES = `STS_STILL_CLOCKS
) (
  input  wire logic        mclk_i,              // system clock, 100 MHz
  input  wire logic        arst_n_i,            // asynchronous reset, active low
  input  wire logic        psel_i,              // apb select
  input  wire logic        penable_i,           // apb enable
  input  wire logic        pwrite_i,            // apb write
  input  wire logic [7:0]  paddr_i,             // apb byte address
  input  wire logic [31:0] pwdata_i,            // apb write data
  output logic      [31:0] prdata_o,            // apb read data
  output logic             pready_o,            // apb ready
  output logic             pslverr_o,           // apb error
  input  wire logic        temp_warn_i,         // warning comparator tripped
  input  wire logic        temp_shut_i,         // shutdown comparator tripped
  input  wire logic        uv_logic_i,          // logic supply undervoltage
  input  wire logic        uv_main_i,           // main supply undervoltage
  input  wire logic        bridge_disable_input_i, // hardware bridge disable
  input  wire logic        s2g_fault_i,         // short-to-ground latch, clockless
  input  wire logic        step_i,              // step input
  input  wire logic        ext_clk_i,           // clock input pin level
  input  wire logic        sif_cs_n_i,          // serial chip select, active low
  input  wire logic        sif_sck_i,           // serial clock level
  input  wire logic        sif_sdi_i,           // serial data in
  output logic             sif_sdo_o,           // serial data out
  output logic             bridge_enable_o,     // power bridge enable
  output logic             osc_enable_o,        // internal oscillator enable
  output logic             clk_sel_ext_o,       // external clock selected
  output logic [1:0]       high_side_drive_o,   // effective high-side drive step
  output logic             logic_run_o          // clocked logic operating
);

  localparam int unsigned POR_CYCLES   = `STS_POR_CYCLES;
  localparam int unsigned STALL_CYCLES = `STS_STALL_CYCLES;

  sts_state_t                   state_reg;
  logic [15:0]                  por_cnt_reg;
  logic                         sys_rst;
  logic                         uv_any;
  logic                         clk_ext_reg;
  logic                         ext_prev_reg;
  logic [15:0]                  stall_cnt_reg;
  logic                         clk_lost_reg;
  logic                         run;
  logic                         warn_reg;
  logic                         shut_reg;
  logic                         bridge_en_reg;
  logic [`STS_CFG_W-1:0]        cfg_reg;
  logic [`STS_CS_W-1:0]         cscale_reg;
  logic [1:0]                   drive_reg;
  logic [1:0]                   hs_slope;
  logic [`STS_CNT_W-1:0]        still_cnt_reg;
  logic                         still_reg;
  logic [`STS_SIF_W-1:0]        sif_sr_reg;
  logic                         sck_prev_reg;
  logic                         cs_prev_reg;
  logic [31:0]                  prdata_reg;
  logic                         pslverr_reg;
  logic [31:0]                  rd_mux;
  logic                         mapped;
  logic                         wr_en;

  assign uv_any  = uv_logic_i | uv_main_i;
  assign sys_rst = (state_reg != ST_RUN);
  assign run     = ~sys_rst & ~clk_lost_reg;
  assign hs_slope = cfg_reg[`STS_CFG_HSLOPE_LSB +: `STS_CFG_HSLOPE_W];

  // reset sequencer: power-up delay, undervoltage hold
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_POR;
    end else begin
      unique case (state_reg)
        ST_POR: begin
          if (uv_any) begin
            state_reg <= ST_UVLO;
          end else if (por_cnt_reg == 16'(POR_CYCLES - 1)) begin
            state_reg <= ST_RUN;
          end
        end
        ST_UVLO: begin
          if (!uv_any) begin
            state_reg <= ST_POR;
          end
        end
        ST_RUN: begin
          if (uv_any) begin
            state_reg <= ST_UVLO;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      por_cnt_reg <= 16'h0000;
    end else if (state_reg == ST_POR) begin
      por_cnt_reg <= por_cnt_reg + 16'h0001;
    end else begin
      por_cnt_reg <= 16'h0000;
    end
  end

  // clock source: first high selects external, held until next reset
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_ext_reg <= 1'b0;
    end else if (sys_rst) begin
      clk_ext_reg <= 1'b0;
    end else if (ext_clk_i) begin
      clk_ext_reg <= 1'b1;
    end
  end

  // stopped external clock: no edge for a stall time halts the logic
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_prev_reg  <= 1'b0;
      stall_cnt_reg <= 16'h0000;
      clk_lost_reg  <= 1'b0;
    end else begin
      ext_prev_reg <= ext_clk_i;
      if (sys_rst || !clk_ext_reg || (ext_clk_i != ext_prev_reg)) begin
        stall_cnt_reg <= 16'h0000;
        clk_lost_reg  <= 1'b0;
      end else if (stall_cnt_reg == 16'(STALL_CYCLES - 1)) begin
        clk_lost_reg  <= 1'b1;
      end else begin
        stall_cnt_reg <= stall_cnt_reg + 16'h0001;
      end
    end
  end

  // temperature flags: warning follows the level, shutdown latches
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      warn_reg <= 1'b0;
      shut_reg <= 1'b0;
    end else if (sys_rst) begin
      warn_reg <= 1'b0;
      shut_reg <= 1'b0;
    end else begin
      warn_reg <= temp_warn_i;
      if (temp_shut_i) begin
        shut_reg <= 1'b1;
      end
    end
  end

  // bridge enable; a zero off time also disables it
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bridge_en_reg <= 1'b0;
    end else begin
      bridge_en_reg <= run & ~shut_reg & ~bridge_disable_input_i
                       & (cfg_reg[`STS_CFG_OFF_TIME_LSB +: `STS_CFG_OFF_TIME_W] != '0);
    end
  end

  // short-to-ground fault cuts the bridge without any clock edge
  assign bridge_enable_o = bridge_en_reg & ~s2g_fault_i;

  // high-side drive, one step up when compensated and warm
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drive_reg <= 2'h0;
    end else if (sys_rst) begin
      drive_reg <= 2'h0;
    end else if (cfg_reg[`STS_CFG_TCOMP] && warn_reg && hs_slope != `STS_HSLOPE_MAX) begin
      drive_reg <= hs_slope + 2'h1;
    end else begin
      drive_reg <= hs_slope;
    end
  end

  // standstill detection
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      still_cnt_reg <= '0;
      still_reg     <= 1'b0;
    end else if (sys_rst) begin
      still_cnt_reg <= '0;
      still_reg     <= 1'b0;
    end else if (run) begin
      if (step_i) begin
        still_cnt_reg <= '0;
        still_reg     <= 1'b0;
      end else if (still_cnt_reg == `STS_CNT_W'(STILL_CYCLES - 1)) begin
        still_reg     <= 1'b1;
      end else begin
        still_cnt_reg <= still_cnt_reg + 1'b1;
      end
    end
  end

  // serial status shift register, held clear in reset
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sif_sr_reg   <= '0;
      sck_prev_reg <= 1'b0;
      cs_prev_reg  <= 1'b1;
    end else if (sys_rst) begin
      sif_sr_reg   <= '0;
      sck_prev_reg <= 1'b0;
      cs_prev_reg  <= 1'b1;
    end else if (run) begin
      sck_prev_reg <= sif_sck_i;
      cs_prev_reg  <= sif_cs_n_i;
      if (cs_prev_reg && !sif_cs_n_i) begin
        sif_sr_reg <= {cscale_reg, `STS_SIF_PAD, still_reg, shut_reg, warn_reg};
      end else if (!sif_cs_n_i && sif_sck_i && !sck_prev_reg) begin
        sif_sr_reg <= {sif_sr_reg[`STS_SIF_W-2:0], sif_sdi_i};
      end
    end
  end

  assign sif_sdo_o = sif_sr_reg[`STS_SIF_W-1];

  // apb decode
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr_i)
      `STS_OFS_STATUS: begin
        rd_mux[`STS_ST_WARN]    = warn_reg;
        rd_mux[`STS_ST_SHUT]    = shut_reg;
        rd_mux[`STS_ST_STILL]   = still_reg;
        rd_mux[`STS_ST_CLKEXT]  = clk_ext_reg;
        rd_mux[`STS_ST_CLKLOST] = clk_lost_reg;
        rd_mux[`STS_ST_RUN]     = ~sys_rst;
      end
      `STS_OFS_CONFIG: rd_mux[`STS_CFG_W-1:0] = cfg_reg;
      `STS_OFS_CSCALE: rd_mux[`STS_CS_W-1:0]  = cscale_reg;
      `STS_OFS_DRIVE:  rd_mux[1:0]            = drive_reg;
      default:         mapped                 = 1'b0;
    endcase
  end

  assign wr_en = psel_i & penable_i & pwrite_i & mapped & ~sys_rst;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel_i && !penable_i) begin
      prdata_reg  <= (sys_rst || pwrite_i) ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= ~mapped;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_reg    <= `STS_CFG_RST;
      cscale_reg <= `STS_CS_RST;
    end else if (sys_rst) begin
      cfg_reg    <= `STS_CFG_RST;
      cscale_reg <= `STS_CS_RST;
    end else if (wr_en && paddr_i == `STS_OFS_CONFIG) begin
      cfg_reg    <= pwdata_i[`STS_CFG_W-1:0];
    end else if (wr_en && paddr_i == `STS_OFS_CSCALE) begin
      cscale_reg <= pwdata_i[`STS_CS_W-1:0];
    end
  end

  assign prdata_o          = prdata_reg;
  assign pslverr_o         = pslverr_reg & psel_i & penable_i;
  assign pready_o          = psel_i & penable_i;
  assign osc_enable_o      = ~clk_ext_reg;
  assign clk_sel_ext_o     = clk_ext_reg;
  assign high_side_drive_o = drive_reg;
  assign logic_run_o       = run;

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_warn_reports: assert property (
    (state_reg == ST_RUN && !uv_any && temp_warn_i) |=> warn_reg)
    else $error("warning flag missed");

  a_shut_bridge_off: assert property (
    (state_reg == ST_RUN && temp_shut_i) |=> shut_reg ##1 !bridge_enable_o [*2])
    else $error("bridge not off after shutdown");

  a_slope_comp_step: assert property (
    (!sys_rst && cfg_reg[`STS_CFG_TCOMP] && warn_reg && hs_slope != `STS_HSLOPE_MAX)
      |=> drive_reg == $past(hs_slope) + 2'h1)
    else $error("slope step not raised");

  a_uv_clears_all: assert property (
    uv_any |=> (state_reg == ST_UVLO) ##1 (cfg_reg == `STS_CFG_RST && !bridge_enable_o))
    else $error("undervoltage did not clear");

  a_uv_serial_zero: assert property (
    (state_reg == ST_UVLO) [*2] |-> sif_sdo_o == 1'b0)
    else $error("serial output not zero in reset");

  a_cs_cleared: assert property (
    sys_rst |=> cscale_reg == `STS_CS_RST)
    else $error("current scale not cleared");

  a_por_ignores: assert property (
    (state_reg == ST_POR && psel_i && penable_i && pwrite_i) |=> cfg_reg == `STS_CFG_RST)
    else $error("write taken during power-up");

  a_still_timing: assert property (
    $rose(still_reg) |-> $past(still_cnt_reg) == `STS_CNT_W'(STILL_CYCLES - 1))
    else $error("standstill raised at wrong count");

  a_clk_switch: assert property (
    (state_reg == ST_RUN && !uv_any && ext_clk_i) |=> clk_ext_reg && !osc_enable_o)
    else $error("external clock not selected");

  a_clk_lost_halt: assert property (
    (clk_lost_reg && !sys_rst) |=> $stable(still_cnt_reg) && !bridge_enable_o)
    else $error("logic ran without clock");

  a_s2g_cut: assert property (
    s2g_fault_i |-> !bridge_enable_o)
    else $error("bridge on during short fault");

  a_clk_sticky: assert property (
    (clk_ext_reg && state_reg == ST_RUN && !uv_any) |=> clk_ext_reg)
    else $error("clock selection dropped");

  c_reach_run:  cover property ($rose(state_reg == ST_RUN));
  c_ext_clock:  cover property ($rose(clk_ext_reg));
  c_shutdown:   cover property ($rose(shut_reg));
  c_standstill: cover property ($rose(still_reg));

endmodule

// File: sts_supervisor_params.svh
/*
  Constants of the supply, temperature and clock supervisor: register offsets,
  field positions, reset values and timing counts.
  Assumes a 100 MHz system clock on mclk_i and a 32-bit APB register bus.
*/
`ifndef STS_SUPERVISOR_PARAMS_SVH
`define STS_SUPERVISOR_PARAMS_SVH

// temperature thresholds of the external comparators, degrees C
`define STS_TEMP_WARN_C       100
`define STS_TEMP_SHUT_C       150

// timing
`define STS_CLK_PERIOD_NS     10
`define STS_POR_TIME_NS       10000
`define STS_POR_CYCLES        ((`STS_POR_TIME_NS + `STS_CLK_PERIOD_NS - 1) / `STS_CLK_PERIOD_NS)
`define STS_STALL_TIME_NS     1000
`define STS_STALL_CYCLES      (`STS_STALL_TIME_NS / `STS_CLK_PERIOD_NS)
`define STS_STILL_CLOCKS      (1 << 20)
`define STS_CNT_W             21

// register byte offsets
`define STS_ADDR_W            8
`define STS_OFS_STATUS        8'h00
`define STS_OFS_CONFIG        8'h04
`define STS_OFS_CSCALE        8'h08
`define STS_OFS_DRIVE         8'h0C

// status fields
`define STS_ST_WARN           0
`define STS_ST_SHUT           1
`define STS_ST_STILL          2
`define STS_ST_CLKEXT         3
`define STS_ST_CLKLOST        4
`define STS_ST_RUN            5

// config fields and reset value
`define STS_CFG_OFF_TIME_LSB  0
`define STS_CFG_OFF_TIME_W    4
`define STS_CFG_HSLOPE_LSB    4
`define STS_CFG_HSLOPE_W      2
`define STS_CFG_TCOMP         6
`define STS_CFG_W             7
`define STS_CFG_RST           7'h00
`define STS_HSLOPE_MAX        2'h3

// current scale
`define STS_CS_W              5
`define STS_CS_RST            5'h00

// serial response frame
`define STS_SIF_W             20
`define STS_SIF_PAD           12'h000

`endif

// File: testbench.sv
/*
  Self-checking bench of the supervisor: APB master tasks, host model on the
  serial link and clock pin, monitor inputs driven directly.
  Assumes a 100 MHz clock and a reduced standstill count.
*/
`timescale 1ns/1ns
`include "sts_supervisor_params.svh"

module testbench;
  localparam logic [7:0] A_STAT = `STS_OFS_STATUS;
  localparam logic [7:0] A_CFG  = `STS_OFS_CONFIG;
  localparam logic [7:0] A_CSC  = `STS_OFS_CSCALE;
  localparam logic [7:0] A_DRV  = `STS_OFS_DRIVE;
  logic        mclk = 1'b0;
  logic        arst_n, psel, penable, pwrite, twarn, tshut, uvl, uvm, dis, s2g, step;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, ext_clk, cs_n, sck, sdi, sdo, br_en, osc_en, clk_ext, run;
  logic [1:0]  drive;
  logic [19:0] fr;
  int          failures, cmp_count;

  always #5 mclk = ~mclk;

  sts_supervisor #(.STILL_CYCLES(64)) sts_supervisor_i (
    .mclk_i(mclk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .temp_warn_i(twarn), .temp_shut_i(tshut), .uv_logic_i(uvl), .uv_main_i(uvm),
    .bridge_disable_input_i(dis), .s2g_fault_i(s2g), .step_i(step), .ext_clk_i(ext_clk),
    .sif_cs_n_i(cs_n), .sif_sck_i(sck), .sif_sdi_i(sdi), .sif_sdo_o(sdo), .bridge_enable_o(br_en),
    .osc_enable_o(osc_en), .clk_sel_ext_o(clk_ext), .high_side_drive_o(drive), .logic_run_o(run));

  sts_host_model sts_host_model_i (
    .mclk_i(mclk), .sdo_i(sdo), .ext_clk_o(ext_clk), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, {31'h0, pready});
      end_sim;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd & m);
  endtask

  task automatic sif(input logic [19:0] din, input logic [19:0] exp);
    sts_host_model_i.xfer(din, fr);
    chk("frame", {12'h0, exp}, {12'h0, fr});
  endtask

  task automatic wait_run;
    int n;
    n = 0;
    while (run !== 1'b1 && n < 1200) begin
      @(posedge mclk);
      n++;
    end
    if (run !== 1'b1) begin
      chk("run", 32'h1, {31'h0, run});
      end_sim;
    end
  endtask

  initial begin
    {arst_n, psel, penable, pwrite, twarn, tshut, uvl, uvm, dis, s2g, step} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    cmp_count = 0;
    repeat (8) @(negedge mclk);
    chk("osc_en", 32'h1, {31'h0, osc_en});
    chk("bridge", 32'h0, {31'h0, br_en});
    @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b1, A_CSC, 32'h1F);
    rchk("status", A_STAT, 32'hFFFFFFFF, 32'h0);
    sif(20'hFFFFF, 20'h0);
    wait_run;
    rchk("cscale", A_CSC, 32'hFFFFFFFF, 32'h0);
    $display("test power_up done");

    apb(1'b1, A_CFG, 32'h51);
    rchk("config", A_CFG, 32'hFFFFFFFF, 32'h51);
    apb(1'b1, A_CSC, 32'h15);
    rchk("cscale", A_CSC, 32'hFFFFFFFF, 32'h15);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rd);
    @(negedge mclk);
    chk("bridge", 32'h1, {31'h0, br_en});
    @(posedge mclk);
    dis <= 1'b1;
    repeat (2) @(negedge mclk);
    chk("bridge", 32'h0, {31'h0, br_en});
    @(posedge mclk);
    dis <= 1'b0;
    repeat (2) @(posedge mclk);
    s2g <= 1'b1;
    @(negedge mclk);
    chk("bridge", 32'h0, {31'h0, br_en});
    @(posedge mclk);
    s2g <= 1'b0;
    $display("test bridge done");

    @(posedge mclk);
    step <= 1'b1;
    @(posedge mclk);
    step <= 1'b0;
    repeat (50) @(posedge mclk);
    rchk("standstill", A_STAT, 32'h04, 32'h0);
    repeat (20) @(posedge mclk);
    rchk("standstill", A_STAT, 32'h04, 32'h04);
    $display("test standstill done");

    rchk("drive", A_DRV, 32'hFFFFFFFF, 32'h1);
    @(posedge mclk);
    twarn <= 1'b1;
    repeat (3) @(posedge mclk);
    rchk("temp", A_STAT, 32'h03, 32'h01);
    rchk("drive", A_DRV, 32'hFFFFFFFF, 32'h2);
    chk("drive_pin", 32'h2, {30'h0, drive});
    sif(20'h0, 20'hA8005);
    apb(1'b1, A_CFG, 32'h11);
    rchk("drive", A_DRV, 32'hFFFFFFFF, 32'h1);
    @(posedge mclk);
    twarn <= 1'b0;
    tshut <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("bridge", 32'h0, {31'h0, br_en});
    @(posedge mclk);
    tshut <= 1'b0;
    rchk("shutdown", A_STAT, 32'h02, 32'h02);
    $display("test temperature done");

    for (int i = 0; i < 2; i++) begin
      apb(1'b1, A_CSC, 32'h15);
      apb(1'b1, A_CFG, 32'h01);
      @(posedge mclk);
      uvl <= (i == 0);
      uvm <= (i == 1);
      repeat (3) @(negedge mclk);
      chk("bridge", 32'h0, {31'h0, br_en});
      sif(20'hFFFFF, 20'h0);
      rchk("status", A_STAT, 32'hFFFFFFFF, 32'h0);
      @(posedge mclk);
      uvl <= 1'b0;
      uvm <= 1'b0;
      wait_run;
      rchk("config", A_CFG, 32'hFFFFFFFF, 32'h0);
      chk("bridge", 32'h0, {31'h0, br_en});
      rchk("shutdown", A_STAT, 32'h02, 32'h0);
      sts_host_model_i.xfer(20'h0, fr);
      chk("level", 32'h0, {27'h0, fr[19:15]});
    end
    $display("test undervoltage done");

    apb(1'b1, A_CFG, 32'h01);
    sts_host_model_i.clk_run(1'b1);
    repeat (20) @(negedge mclk);
    chk("clk_ext", 32'h1, {31'h0, clk_ext});
    chk("osc_en", 32'h0, {31'h0, osc_en});
    rchk("clk_stat", A_STAT, 32'h08, 32'h08);
    @(posedge mclk);
    dis <= 1'b1;
    repeat (2) @(negedge mclk);
    chk("bridge", 32'h0, {31'h0, br_en});
    sts_host_model_i.clk_run(1'b0);
    repeat (120) @(negedge mclk);
    chk("run", 32'h0, {31'h0, run});
    rchk("lost", A_STAT, 32'h30, 32'h30);
    chk("clk_ext", 32'h1, {31'h0, clk_ext});
    sts_host_model_i.clk_run(1'b1);
    repeat (10) @(negedge mclk);
    chk("run", 32'h1, {31'h0, run});
    sts_host_model_i.clk_run(1'b0);
    repeat (8) @(posedge mclk);
    uvm <= 1'b1;
    repeat (3) @(posedge mclk);
    uvm <= 1'b0;
    wait_run;
    @(negedge mclk);
    chk("clk_ext", 32'h0, {31'h0, clk_ext});
    chk("osc_en", 32'h1, {31'h0, osc_en});
    $display("test clock done");
    end_sim;
  end
endmodule
